// file: rtl/esh_pkg.sv
// Constants and types shared by the error status and history objects
package esh_pkg;

    // ------------------------------------------------------------------
    // Object dictionary indices and sub-indices
    // ------------------------------------------------------------------
    localparam logic [15:0] IDX_DEVTYPE = 16'h1000;
    localparam logic [15:0] IDX_ERRFLAG = 16'h1001;
    localparam logic [15:0] IDX_HIST = 16'h1003;
    localparam logic [7:0] SUB_COUNT = 8'h00;
    localparam logic [7:0] SUB_MAX = 8'h0f;

    // ------------------------------------------------------------------
    // Function block bitmap of the device type word
    // ------------------------------------------------------------------
    localparam logic [15:0] FB_DI = 16'h0001;
    localparam logic [15:0] FB_AI = 16'h0002;
    localparam logic [15:0] FB_DO = 16'h0004;
    localparam logic [15:0] FB_AO = 16'h0008;
    localparam logic [15:0] FB_CTRL = 16'h0010;
    localparam logic [15:0] FB_ALARM = 16'h0020;
    localparam logic [15:0] FB_LUT = 16'h2000;
    localparam logic [15:0] FB_LOGIC = 16'h4000;
    localparam logic [15:0] FB_MISC = 16'h8000;
    localparam logic [15:0] FB_LEGAL = FB_DI | FB_AI | FB_DO | FB_AO
        | FB_CTRL | FB_ALARM | FB_LUT | FB_LOGIC | FB_MISC;
    localparam int DEVTYPE_ADD_LSB = 16;

    // ------------------------------------------------------------------
    // Generic error flag
    // ------------------------------------------------------------------
    localparam int FLAG_BIT = 0;
    localparam logic [7:0] FLAG_RESET = 8'h00;

    // ------------------------------------------------------------------
    // History entry layout and codes
    // ------------------------------------------------------------------
    localparam int EMCY_LSB = 0;
    localparam int CHAN_LSB = 16;
    localparam int DESC_LSB = 24;
    localparam int HIST_DEPTH = 4;
    localparam logic [31:0] ENTRY_RESET = 32'h0000_0000;
    localparam logic [31:0] CODE_ERR_RESET = 32'h0000_0000;
    localparam logic [15:0] EMCY_AI_OVL = 16'hf001;
    localparam logic [15:0] EMCY_AO_OPEN = 16'hf002;
    localparam logic [15:0] EMCY_VOLT = 16'h3000;
    localparam logic [15:0] EMCY_COMM = 16'h8100;
    localparam logic [15:0] EMCY_GUARD = 16'h8130;
    localparam logic [7:0] DESC_HIGH = 8'h20;
    localparam logic [7:0] DESC_LOW = 8'h40;
    localparam logic [7:0] DESC_BREAK = 8'h10;
    localparam logic [7:0] DESC_NONE = 8'h00;
    localparam logic [7:0] DESC_LIFE = 8'h10;
    localparam logic [7:0] DESC_HBEAT = 8'h80;
    localparam logic [7:0] CHAN_NONE = 8'h00;

    // ------------------------------------------------------------------
    // Fault source numbering
    // ------------------------------------------------------------------
    localparam int N_AI = 7;
    localparam int N_AO = 5;
    localparam int SRC_AI_HI = 0;
    localparam int SRC_AI_LO = 7;
    localparam int SRC_AO = 14;
    localparam int SRC_OVER = 19;
    localparam int SRC_UNDER = 20;
    localparam int SRC_RPDO = 21;
    localparam int SRC_LIFE = 22;
    localparam int SRC_HBEAT = 23;
    localparam int N_SRC = 24;

    // Event kind, Gray coded along none -> raise -> clear
    typedef enum logic [1:0] {
        EV_NONE = 2'b00,
        EV_RAISE = 2'b01,
        EV_CLEAR = 2'b11
    } esh_evt_t;

endpackage

// file: rtl/esh_hist.sv
// Newest-first error history list with insert, remove and flush
`timescale 1ns/1ps
module esh_hist
    import esh_pkg::*;
#(
    parameter int DEPTH = HIST_DEPTH,
    parameter int CW = $clog2(DEPTH + 1)
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ins,
    input wire logic [31:0] ins_code,
    input wire logic del,
    input wire logic [31:0] del_code,
    input wire logic flush,
    output logic [DEPTH*32-1:0] entries,
    output logic [CW-1:0] count,
    output logic del_hit
);

    // Elaboration stops on a depth the sub-index decode cannot reach
    if (DEPTH < 1 || DEPTH > 15) begin : g_bad_depth
        $error("esh_hist: DEPTH must be 1 to 15");
    end

    logic [31:0] ent_r [DEPTH];
    logic [31:0] ent_nxt [DEPTH];
    logic [CW-1:0] count_r;
    logic [CW-1:0] count_nxt;
    logic [DEPTH-1:0] match;
    logic [DEPTH-1:0] gone;
    logic full;

    // ------------------------------------------------------------------
    // Next list contents
    // ------------------------------------------------------------------
    assign full = (count_r == CW'(DEPTH));
    assign del_hit = del && (|match);

    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : g_ent
            logic [31:0] above;
            logic [31:0] below;
            // Only live entries may match a clearing fault
            assign match[i] = (CW'(i) < count_r) && (ent_r[i] == del_code);
            // First match and all older entries move up one place
            if (i == 0) begin : g_first
                assign gone[i] = match[i];
                assign above = ins_code;
            end else begin : g_rest
                assign gone[i] = match[i] | gone[i-1];
                assign above = ent_r[i-1];
            end
            if (i == DEPTH - 1) begin : g_last
                assign below = ENTRY_RESET;
            end else begin : g_mid
                assign below = ent_r[i+1];
            end
            // Flush beside an insert keeps the new fault
            assign ent_nxt[i] =
                (flush && ins) ? ((i == 0) ? ins_code : ENTRY_RESET) :
                flush ? ENTRY_RESET :
                ins ? above :
                (del && gone[i]) ? below : ent_r[i];
            assign entries[i*32 +: 32] = ent_r[i];
        end
    endgenerate

    // Insert past full drops the oldest; count saturates at DEPTH
    assign count_nxt =
        (flush && ins) ? CW'(1) :
        flush ? '0 :
        ins ? (full ? count_r : count_r + CW'(1)) :
        del_hit ? count_r - CW'(1) : count_r;
    assign count = count_r;

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_r <= '0;
            for (int k = 0; k < DEPTH; k++) begin
                ent_r[k] <= ENTRY_RESET;
            end
        end else begin
            count_r <= count_nxt;
            for (int k = 0; k < DEPTH; k++) begin
                ent_r[k] <= ent_nxt[k];
            end
        end
    end

endmodule // esh_hist

// file: rtl/esh_objects.sv
// Device type, generic error flag and error history objects
`timescale 1ns/1ps
module esh_objects
    import esh_pkg::*;
#(
    // Arbitrary values; set per product
    parameter logic [15:0] ADD_INFO = FB_DI | FB_AI | FB_DO | FB_AO,
    parameter logic [15:0] PROFILE_NO = 16'h0001,
    parameter int DEPTH = HIST_DEPTH
) (
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic OD_RD,
    input wire logic OD_WR,
    input wire logic [15:0] OD_INDEX,
    input wire logic [7:0] OD_SUBINDEX,
    input wire logic [31:0] OD_WDATA,
    output logic [31:0] OD_RDATA,
    output logic OD_ACK,
    output logic OD_ABORT,
    input wire logic [N_AI-1:0] AI_HIGH,
    input wire logic [N_AI-1:0] AI_LOW,
    input wire logic [N_AO-1:0] OUT_OPEN,
    input wire logic SUPPLY_OVER,
    input wire logic SUPPLY_UNDER,
    input wire logic RPDO_LATE,
    input wire logic LIFEGUARD,
    input wire logic HBEAT_MISS,
    input wire logic [7:0] HBEAT_NODE,
    output logic GENERIC_ERROR,
    output logic EMCY_VALID,
    output logic [31:0] EMCY_CODE
);

    localparam int CW = $clog2(DEPTH + 1);

    // Reserved bitmap positions must stay clear
    if ((ADD_INFO & ~FB_LEGAL) != 16'h0000) begin : g_bad_info
        $error("esh_objects: ADD_INFO sets reserved bits");
    end
    if (DEPTH < 1 || DEPTH > 15) begin : g_bad_depth
        $error("esh_objects: DEPTH must be 1 to 15");
    end

    // ------------------------------------------------------------------
    // Fault code per source
    // ------------------------------------------------------------------
    function automatic logic [31:0] src_code(input int k,
                                             input logic [7:0] node);
        logic [7:0] desc;
        logic [7:0] chan;
        logic [15:0] emcy;
        desc = DESC_NONE;
        chan = CHAN_NONE;
        emcy = EMCY_COMM;
        if (k < SRC_AI_LO) begin
            desc = DESC_HIGH;
            chan = 8'(1 << (k - SRC_AI_HI));
            emcy = EMCY_AI_OVL;
        end else if (k < SRC_AO) begin
            desc = DESC_LOW;
            chan = 8'(1 << (k - SRC_AI_LO));
            emcy = EMCY_AI_OVL;
        end else if (k < SRC_OVER) begin
            desc = DESC_BREAK;
            chan = 8'(1 << (k - SRC_AO));
            emcy = EMCY_AO_OPEN;
        end else if (k == SRC_OVER) begin
            desc = DESC_HIGH;
            emcy = EMCY_VOLT;
        end else if (k == SRC_UNDER) begin
            desc = DESC_LOW;
            emcy = EMCY_VOLT;
        end else if (k == SRC_LIFE) begin
            desc = DESC_LIFE;
            emcy = EMCY_GUARD;
        end else if (k == SRC_HBEAT) begin
            desc = DESC_HBEAT;
            chan = node;
            emcy = EMCY_GUARD;
        end
        // Entry packing of description, channel and code
        src_code = (32'(desc) << DESC_LSB) | (32'(chan) << CHAN_LSB)
            | (32'(emcy) << EMCY_LSB);
    endfunction

    // Lowest pending source wins; the rest wait a cycle each
    function automatic logic [4:0] first_set(input logic [N_SRC-1:0] v);
        first_set = 5'h00;
        for (int k = N_SRC - 1; k >= 0; k--) begin
            if (v[k]) begin
                first_set = 5'(k);
            end
        end
    endfunction

    // ------------------------------------------------------------------
    // Fault tracking
    // ------------------------------------------------------------------
    logic [N_SRC-1:0] act;
    logic [N_SRC-1:0] logged_r;
    logic [N_SRC-1:0] logged_nxt;
    logic [N_SRC-1:0] pend;
    logic [4:0] sel;
    logic [7:0] hb_node_r;
    logic [7:0] hb_node_nxt;
    logic flag_r;
    logic any_act;
    esh_evt_t evt;
    logic [31:0] raise_code;
    logic [31:0] clear_code;

    // Monitors share this clock, so the fault levels need no synchroniser
    assign act = {HBEAT_MISS, LIFEGUARD, RPDO_LATE, SUPPLY_UNDER,
                  SUPPLY_OVER, OUT_OPEN, AI_LOW, AI_HIGH};
    assign any_act = |act;
    assign pend = act ^ logged_r;
    assign sel = first_set(pend);
    assign evt = (pend == '0) ? EV_NONE :
                 act[sel] ? EV_RAISE : EV_CLEAR;
    // A clear must name the node that raised it, not the current one
    assign raise_code = src_code(int'(sel), HBEAT_NODE);
    assign clear_code = src_code(int'(sel), hb_node_r);

    // Bookkeeping follows one source per cycle
    always_comb begin
        logged_nxt = logged_r;
        if (evt != EV_NONE) begin
            logged_nxt[sel] = act[sel];
        end
    end
    assign hb_node_nxt = (evt == EV_RAISE && sel == 5'(SRC_HBEAT)) ?
        HBEAT_NODE : hb_node_r;

    // Generic bit follows live faults, not the list, so a flush keeps it
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            logged_r <= '0;
            hb_node_r <= CHAN_NONE;
            flag_r <= FLAG_RESET[FLAG_BIT];
        end else begin
            logged_r <= logged_nxt;
            hb_node_r <= hb_node_nxt;
            flag_r <= any_act;
        end
    end
    assign GENERIC_ERROR = flag_r;

    // ------------------------------------------------------------------
    // Emergency event output
    // ------------------------------------------------------------------
    logic emcy_valid_r;
    logic [31:0] emcy_code_r;
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            emcy_valid_r <= 1'b0;
            emcy_code_r <= CODE_ERR_RESET;
        end else begin
            emcy_valid_r <= (evt != EV_NONE);
            emcy_code_r <= (evt == EV_RAISE) ? raise_code :
                           CODE_ERR_RESET;
        end
    end
    assign EMCY_VALID = emcy_valid_r;
    assign EMCY_CODE = emcy_code_r;

    // ------------------------------------------------------------------
    // Object dictionary decode
    // ------------------------------------------------------------------
    logic req;
    logic hit_dev;
    logic hit_flag;
    logic hit_cnt;
    logic hit_ent;
    logic rd_ok;
    logic wr_ok;
    logic flush;
    logic [3:0] ent_idx;

    // A write takes precedence when both strobes arrive together
    assign req = OD_RD | OD_WR;
    assign hit_dev = (OD_INDEX == IDX_DEVTYPE) && (OD_SUBINDEX == SUB_COUNT);
    assign hit_flag = (OD_INDEX == IDX_ERRFLAG) && (OD_SUBINDEX == SUB_COUNT);
    assign hit_cnt = (OD_INDEX == IDX_HIST) && (OD_SUBINDEX == SUB_COUNT);
    assign hit_ent = (OD_INDEX == IDX_HIST) && (OD_SUBINDEX != SUB_COUNT)
        && (OD_SUBINDEX <= 8'(DEPTH)) && (OD_SUBINDEX <= SUB_MAX);
    assign ent_idx = 4'(OD_SUBINDEX - 8'h01);
    assign rd_ok = OD_RD && !OD_WR
        && (hit_dev || hit_flag || hit_cnt || hit_ent);
    // Only the count accepts a write, and only the value zero
    assign wr_ok = OD_WR && hit_cnt && (OD_WDATA == 32'h0000_0000);
    assign flush = wr_ok;

    // ------------------------------------------------------------------
    // History list
    // ------------------------------------------------------------------
    logic [DEPTH*32-1:0] entries;
    logic [CW-1:0] count;
    logic del_hit;
    logic ins;
    logic del;

    assign ins = (evt == EV_RAISE);
    assign del = (evt == EV_CLEAR);

    esh_hist #(
        .DEPTH(DEPTH),
        .CW(CW)
    ) u_hist (
        .clk(SYS_CLK),
        .rst(RESET),
        .ins(ins),
        .ins_code(raise_code),
        .del(del),
        .del_code(clear_code),
        .flush(flush),
        .entries(entries),
        .count(count),
        .del_hit(del_hit)
    );

    // ------------------------------------------------------------------
    // Read data and answer
    // ------------------------------------------------------------------
    logic [31:0] rd_word;
    logic [31:0] rdata_r;
    logic ack_r;
    logic abort_r;

    // Flag object has a single live bit; everything above reads zero
    assign rd_word =
        hit_dev ? {ADD_INFO, PROFILE_NO} :
        hit_flag ? 32'(flag_r) << FLAG_BIT :
        hit_cnt ? 32'(count) :
        hit_ent ? entries[ent_idx*32 +: 32] : 32'h0000_0000;

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            rdata_r <= 32'h0000_0000;
            ack_r <= 1'b0;
            abort_r <= 1'b0;
        end else begin
            rdata_r <= rd_ok ? rd_word : 32'h0000_0000;
            ack_r <= rd_ok | wr_ok;
            abort_r <= req && !(rd_ok | wr_ok);
        end
    end
    assign OD_RDATA = rdata_r;
    assign OD_ACK = ack_r;
    assign OD_ABORT = abort_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_devtype_read: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        (OD_RD && !OD_WR && hit_dev) |=> OD_ACK
            && OD_RDATA == {ADD_INFO, PROFILE_NO})
        else $error("device type read wrong");

    a_devtype_bitmap: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        OD_ACK && $past(hit_dev) |->
            (OD_RDATA[31:DEVTYPE_ADD_LSB] & ~FB_LEGAL) == 16'h0000)
        else $error("reserved function block bit set");

    a_flag_sets: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        any_act |=> GENERIC_ERROR)
        else $error("generic bit missed an error");

    a_flag_clears: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        !any_act [*2] |-> !GENERIC_ERROR)
        else $error("generic bit stuck without errors");

    a_flag_upper_zero: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        OD_ACK && $past(hit_flag) |-> OD_RDATA[31:1] == 31'h0)
        else $error("flag object upper bits not zero");

    a_insert_head: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        ins |=> entries[31:0] == $past(raise_code))
        else $error("new error not at head");

    a_clear_removes: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        (del_hit && !flush) |=> count == $past(count) - CW'(1))
        else $error("cleared error not removed");

    a_flush_empty: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        (flush && !ins) |=> count == '0 && entries[31:0] == ENTRY_RESET)
        else $error("flush left entries");

    a_flush_keeps_flag: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        (flush && any_act) ##1 any_act |-> GENERIC_ERROR && count <= CW'(1))
        else $error("flush dropped the generic bit");

    a_count_cap: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        (ins && count == CW'(DEPTH) && !flush) |=> count == CW'(DEPTH)
            && entries[32 +: 32] == $past(entries[31:0]))
        else $error("full list handled wrong");

    a_lifeguard_code: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        (ins && sel == 5'(SRC_LIFE)) |=> entries[31:0] == 32'h1000_8130)
        else $error("lifeguard entry wrong");

    a_timeout_code: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        (ins && sel == 5'(SRC_RPDO)) |=> entries[31:0] == 32'h0000_8100)
        else $error("receive timeout entry wrong");

    a_emcy_reset: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        del |=> EMCY_VALID && EMCY_CODE == CODE_ERR_RESET)
        else $error("clear not announced with zero code");

    a_gap_close: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        (del && u_hist.match[2:0] == 3'b100 && !flush)
            |=> entries[95:64] == $past(entries[127:96])
            && entries[63:0] == $past(entries[63:0]))
        else $error("gap not closed");

endmodule // esh_objects

// file: testbench/esh_master.sv
// Network master model that reaches the objects over the object bus
`timescale 1ns/1ps
module esh_master (
    input wire logic clk,
    output logic od_rd,
    output logic od_wr,
    output logic [15:0] od_index,
    output logic [7:0] od_subindex,
    output logic [31:0] od_wdata,
    input wire logic [31:0] od_rdata,
    input wire logic od_ack,
    input wire logic od_abort
);
    // ------------------------------------------------------------------
    // Bus idle at time zero
    // ------------------------------------------------------------------
    initial begin
        od_rd = 1'b0;
        od_wr = 1'b0;
        od_index = 16'h0000;
        od_subindex = 8'h00;
        od_wdata = 32'h0000_0000;
    end

    // One pulsed request; answer taken one edge later. Idle qualifiers
    // are inverted so no stale value can pass for a held one.
    task automatic access(input logic wr, input logic [15:0] idx,
            input logic [7:0] sub, input logic [31:0] wd,
            output logic [31:0] rd, output logic [1:0] resp);
        @(posedge clk);
        od_rd <= ~wr;
        od_wr <= wr;
        od_index <= idx;
        od_subindex <= sub;
        od_wdata <= wd;
        @(posedge clk);
        od_rd <= 1'b0;
        od_wr <= 1'b0;
        od_index <= ~idx;
        od_subindex <= ~sub;
        od_wdata <= ~wd;
        #1;
        rd = od_rdata;
        resp = {od_abort, od_ack};
    endtask
endmodule // esh_master

// file: testbench/test_error_status_history_objects.sv
// Self-checking bench for the error status and history objects
`timescale 1ns/1ps
module test_error_status_history_objects;
    import esh_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic od_rd, od_wr, od_ack, od_abort, gen_err, emcy_valid;
    logic [15:0] od_index;
    logic [7:0] od_subindex;
    logic [31:0] od_wdata, od_rdata, emcy_code;
    logic [31:0] last_emcy = 32'hffff_ffff;
    logic [23:0] flt = 24'h0;
    logic [7:0] node = 8'h5a;
    int errors = 0;
    int checked = 0;

    esh_objects dut (.SYS_CLK(clk), .RESET(rst), .OD_RD(od_rd),
        .OD_WR(od_wr), .OD_INDEX(od_index), .OD_SUBINDEX(od_subindex),
        .OD_WDATA(od_wdata), .OD_RDATA(od_rdata), .OD_ACK(od_ack),
        .OD_ABORT(od_abort), .AI_HIGH(flt[6:0]), .AI_LOW(flt[13:7]),
        .OUT_OPEN(flt[18:14]), .SUPPLY_OVER(flt[19]),
        .SUPPLY_UNDER(flt[20]), .RPDO_LATE(flt[21]), .LIFEGUARD(flt[22]),
        .HBEAT_MISS(flt[23]), .HBEAT_NODE(node), .GENERIC_ERROR(gen_err),
        .EMCY_VALID(emcy_valid), .EMCY_CODE(emcy_code));
    esh_master mst (.clk(clk), .od_rd(od_rd), .od_wr(od_wr),
        .od_index(od_index), .od_subindex(od_subindex),
        .od_wdata(od_wdata), .od_rdata(od_rdata), .od_ack(od_ack),
        .od_abort(od_abort));

    // ------------------------------------------------------------------
    // Clock, reset and event capture
    // ------------------------------------------------------------------
    initial begin
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
    end
    // Event pulses last one cycle, so keep the latest code
    always @(posedge clk) begin
        if (emcy_valid === 1'b1) begin
            last_emcy <= emcy_code;
        end
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Expected entry per source, from the code table; inputs 1-7 one-hot
    function automatic logic [31:0] exp_code(input int s);
        if (s < 7) return {8'h20, 8'h01 << s, 16'hf001};
        if (s < 14) return {8'h40, 8'h01 << (s - 7), 16'hf001};
        if (s < 19) return {8'h10, 8'h01 << (s - 14), 16'hf002};
        case (s)
            19: return 32'h2000_3000;
            20: return 32'h4000_3000;
            21: return 32'h0000_8100;
            22: return 32'h1000_8130;
            default: return {8'h80, node, 16'h8130};
        endcase
    endfunction

    task automatic chk(input string name, input logic [31:0] exp,
            input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Resp is {abort, ack}; data compared on reads only
    task automatic xfer(input logic wr, input string name,
            input logic [15:0] idx, input logic [7:0] sub,
            input logic [31:0] wd, input logic [31:0] exp,
            input logic [1:0] eresp);
        logic [31:0] d;
        logic [1:0] r;
        mst.access(wr, idx, sub, wd, d, r);
        chk({name, " resp"}, {30'h0, eresp}, {30'h0, r});
        if (!wr) begin
            chk(name, exp, d);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic finish_test();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Hang guard, far above the few hundred cycles the tests need
    initial begin
        for (int n = 0; n < 20000; n++) @(posedge clk);
        errors++;
        $display("mismatch timeout expected done seen running");
        finish_test();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        @(negedge rst);
        xfer(0, "devtype", 16'h1000, 8'h00, 0, 32'h000f_0001, 2'b01);
        xfer(0, "flag", 16'h1001, 8'h00, 0, 0, 2'b01);
        xfer(0, "count", 16'h1003, 8'h00, 0, 0, 2'b01);
        xfer(1, "devtype wr", 16'h1000, 8'h00, 1, 0, 2'b10);
        xfer(0, "devtype sub", 16'h1000, 8'h01, 0, 0, 2'b10);
        xfer(0, "unmapped", 16'h1002, 8'h00, 0, 0, 2'b10);
        // Each source raised and cleared alone
        for (int s = 0; s < 24; s++) begin
            @(posedge clk);
            flt[s] <= 1'b1;
            settle(3);
            chk("raise code", exp_code(s), last_emcy);
            chk("error pin", 1, {31'h0, gen_err});
            xfer(0, "entry", 16'h1003, 8'h01, 0, exp_code(s), 2'b01);
            xfer(0, "flag", 16'h1001, 8'h00, 0, 1, 2'b01);
            @(posedge clk);
            flt[s] <= 1'b0;
            node <= ~node;
            settle(3);
            chk("clear code", 0, last_emcy);
            xfer(0, "count", 16'h1003, 8'h00, 0, 0, 2'b01);
            xfer(0, "flag", 16'h1001, 8'h00, 0, 0, 2'b01);
        end
        // Five at once: lowest first, oldest dropped
        @(posedge clk);
        flt[4:0] <= 5'h1f;
        settle(8);
        xfer(0, "count", 16'h1003, 8'h00, 0, 4, 2'b01);
        for (int k = 1; k <= 4; k++) begin
            xfer(0, "entry", 16'h1003, 8'(k), 0, exp_code(5 - k), 2'b01);
        end
        xfer(0, "past depth", 16'h1003, 8'h05, 0, 0, 2'b10);
        // Middle entry leaves, the rest close up
        @(posedge clk);
        flt[2] <= 1'b0;
        settle(3);
        xfer(0, "count", 16'h1003, 8'h00, 0, 3, 2'b01);
        for (int k = 1; k <= 3; k++) begin
            xfer(0, "entry", 16'h1003, 8'(k), 0,
                exp_code(k == 3 ? 1 : 5 - k), 2'b01);
        end
        xfer(0, "past count", 16'h1003, 8'h04, 0, 0, 2'b01);
        xfer(1, "flush nonzero", 16'h1003, 8'h00, 1, 0, 2'b10);
        xfer(1, "flush", 16'h1003, 8'h00, 0, 0, 2'b01);
        xfer(0, "count", 16'h1003, 8'h00, 0, 0, 2'b01);
        xfer(0, "flag", 16'h1001, 8'h00, 0, 1, 2'b01);
        @(posedge clk);
        flt <= 24'h0;
        settle(8);
        xfer(0, "flag", 16'h1001, 8'h00, 0, 0, 2'b01);
        finish_test();
    end
endmodule // test_error_status_history_objects
